// ==== hw/lsac_pkg.sv ====
`default_nettype none
package lsac_pkg;
	// register byte offsets on the host bus
	localparam logic [7:0] LSAC_OFF_MEM_DATA = 8'h00;
	localparam logic [7:0] LSAC_OFF_MEM_ADDR = 8'h04;
	localparam logic [7:0] LSAC_OFF_MEM_CMD = 8'h08;
	localparam logic [7:0] LSAC_OFF_EXT_STAT = 8'h0C;
	localparam logic [7:0] LSAC_OFF_CHG_QUEUE = 8'h10;
	localparam logic [7:0] LSAC_OFF_ARB_EN = 8'h14;
	localparam logic [7:0] LSAC_OFF_XMIT_DEST = 8'h18;
	localparam logic [7:0] LSAC_OFF_HDLC_CMD = 8'h1C;
	localparam logic [7:0] LSAC_OFF_HDLC_STAT = 8'h20;
	localparam logic [7:0] LSAC_OFF_INT_CLR = 8'h24;
	localparam logic [7:0] LSAC_OFF_INT_EN = 8'h28;

	// command codes
	localparam logic [7:0] LSAC_CMD_MEM_WRITE = 8'h48;
	localparam logic [7:0] LSAC_CMD_MEM_READ = 8'hC8;
	localparam logic [7:0] LSAC_HCMD_XMIT_END = 8'h0A;
	localparam logic [7:0] LSAC_HCMD_RX_RESET = 8'h80;

	// status values and bit positions
	localparam logic [7:0] LSAC_EXT_QUEUE_VALID = 8'h40;
	localparam int LSAC_INT_XPR_BIT = 4;
	localparam int LSAC_INT_CHG_BIT = 6;
	localparam int LSAC_INT_OVF_BIT = 0;
	localparam logic [7:0] LSAC_INT_MASK = 8'h51;

	// connection memory field layout
	localparam int LSAC_DIR_BIT = 7;
	localparam int LSAC_CODE_LSB = 2;
	localparam int LSAC_ARB_BIT = 4;
	localparam logic [7:0] LSAC_CODE_FILL = 8'hC3;

	// reset values
	localparam logic [7:0] LSAC_RST_BYTE = 8'h00;
	localparam logic [7:0] LSAC_RST_INT_EN = 8'h50;
	localparam logic [7:0] LSAC_RST_MEM = 8'hFF;

	// change queue geometry
	localparam int LSAC_Q_AW = 4;
	localparam int LSAC_Q_DEPTH = 16;

	// bus answer state, one-hot
	typedef enum logic [2:0]
	{
		LSAC_ST_IDLE = 3'b001,
		LSAC_ST_LOAD = 3'b010,
		LSAC_ST_DONE = 3'b100
	} lsac_bus_st_t;
endpackage
`default_nettype wire

// ==== hw/lsac_change_queue.sv ====
`default_nettype none
module lsac_change_queue
	import lsac_pkg::*;
(
	input wire logic clk_in, // system clock
	input wire logic sys_rst_in, // sync reset, high
	input wire logic push_in, // store one entry
	input wire logic [7:0] push_data_in, // entry to store
	input wire logic pop_in, // drop oldest entry
	output logic [7:0] head_out, // oldest entry
	output logic empty_out, // no entry held
	output logic full_out // no room left
);
	logic [7:0] mem_q [LSAC_Q_DEPTH];
	logic [LSAC_Q_AW:0] wr_q;
	logic [LSAC_Q_AW:0] rd_q;
	wire do_pop = pop_in & ~empty_out;
	wire do_push = push_in & (~full_out | do_pop);

	// pointers carry one extra bit to tell full from empty
	assign empty_out = (wr_q == rd_q);
	assign full_out = (wr_q[LSAC_Q_AW] != rd_q[LSAC_Q_AW]) &&
		(wr_q[LSAC_Q_AW-1:0] == rd_q[LSAC_Q_AW-1:0]);
	assign head_out = mem_q[rd_q[LSAC_Q_AW-1:0]];

	// storage has no reset; only entries between the pointers are ever read
	always_ff @(posedge clk_in)
	begin
		if (do_push)
			mem_q[wr_q[LSAC_Q_AW-1:0]] <= push_data_in;
	end

	// pointer update
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (do_push)
				wr_q <= wr_q + 1'b1;
			if (do_pop)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // lsac_change_queue
`default_nettype wire

// ==== hw/lsac_top.sv ====
`default_nettype none
module lsac_top
	import lsac_pkg::*;
(
	input wire logic clk_in, // 200 MHz system clock
	input wire logic sys_rst_in, // sync reset, high
	input wire logic psel_in, // apb select
	input wire logic penable_in, // apb access phase
	input wire logic pwrite_in, // apb direction
	input wire logic [11:0] paddr_in, // apb byte address
	input wire logic [31:0] pwdata_in, // apb write data
	output logic [31:0] prdata_out, // apb read data
	output logic pready_out, // apb ready
	output logic pslverr_out, // apb error, unmapped
	output logic irq_out, // interrupt level, high
	input wire logic ci_up_valid_in, // upstream code strobe
	input wire logic [6:0] ci_up_addr_in, // upstream slot address
	input wire logic [3:0] ci_up_code_in, // upstream code
	input wire logic ci_dn_req_in, // downstream code request
	input wire logic [6:0] ci_dn_addr_in, // downstream slot address
	output logic ci_dn_valid_out, // downstream code ready
	output logic [3:0] ci_dn_code_out, // downstream code
	output logic [7:0] xmit_channel_out, // hdlc destination channel
	output logic xmit_start_out, // hdlc send pulse
	output logic rx_reset_out, // hdlc receive reset pulse
	input wire logic xmit_done_in // hdlc pool emptied pulse
);
	// connection memory: top address bit set for upstream entries
	logic [7:0] cm_q [256];
	logic [7:0] mem_data_q;
	logic [7:0] mem_data_d;
	logic [7:0] mem_addr_q;
	logic [7:0] arb_en_q;
	logic [7:0] xmit_dest_q;
	logic [7:0] int_stat_q;
	logic [7:0] int_stat_d;
	logic [7:0] int_en_q;
	logic cm_wr_pend_q;
	logic xmit_busy_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	logic irq_q;
	logic ci_dn_valid_q;
	logic [3:0] ci_dn_code_q;
	logic xmit_start_q;
	logic rx_reset_q;
	lsac_bus_st_t st_q;
	lsac_bus_st_t st_d;
	logic [7:0] q_head;
	logic q_empty;
	logic q_full;

	// code field of a memory byte
	function automatic logic [3:0] code_of(input logic [7:0] b);
		code_of = b[LSAC_CODE_LSB+3:LSAC_CODE_LSB];
	endfunction

	// arbitration channel of a slot address: port in [1:0], slot in [6:2]
	function automatic logic [2:0] chan_of(input logic [6:0] a);
		chan_of = a[6:4];
	endfunction

	// address decode
	wire [7:0] off = paddr_in[7:0];
	wire in_range = (paddr_in[11:8] == 4'h0) && (off[1:0] == 2'b00);
	wire hit_data = in_range && (off == LSAC_OFF_MEM_DATA);
	wire hit_addr = in_range && (off == LSAC_OFF_MEM_ADDR);
	wire hit_cmd = in_range && (off == LSAC_OFF_MEM_CMD);
	wire hit_ext = in_range && (off == LSAC_OFF_EXT_STAT);
	wire hit_queue = in_range && (off == LSAC_OFF_CHG_QUEUE);
	wire hit_arb = in_range && (off == LSAC_OFF_ARB_EN);
	wire hit_dest = in_range && (off == LSAC_OFF_XMIT_DEST);
	wire hit_hcmd = in_range && (off == LSAC_OFF_HDLC_CMD);
	wire hit_hstat = in_range && (off == LSAC_OFF_HDLC_STAT);
	wire hit_clr = in_range && (off == LSAC_OFF_INT_CLR);
	wire hit_en = in_range && (off == LSAC_OFF_INT_EN);
	wire hit_any = hit_data | hit_addr | hit_cmd | hit_ext | hit_queue | hit_arb |
		hit_dest | hit_hcmd | hit_hstat | hit_clr | hit_en;

	// a transfer commits only at the edge where ready is seen high
	wire commit = psel_in & penable_in & pready_q;
	wire wr_ok = commit & pwrite_in & hit_any;
	wire rd_ok = commit & ~pwrite_in & hit_any;
	wire [7:0] wbyte = pwdata_in[7:0];
	wire wr_cmd_store = wr_ok & hit_cmd & (wbyte == LSAC_CMD_MEM_WRITE);
	wire wr_cmd_fetch = wr_ok & hit_cmd & (wbyte == LSAC_CMD_MEM_READ);
	wire wr_hcmd_xmit = wr_ok & hit_hcmd & (wbyte == LSAC_HCMD_XMIT_END);
	wire wr_hcmd_rres = wr_ok & hit_hcmd & (wbyte == LSAC_HCMD_RX_RESET);
	wire rd_pop = rd_ok & hit_queue;

	// upstream code changes: compare against the stored upstream entry
	wire [7:0] up_addr = {1'b1, ci_up_addr_in};
	wire [7:0] up_old = cm_q[up_addr];
	wire up_change = ci_up_valid_in && (code_of(up_old) != ci_up_code_in);
	wire [7:0] up_new = LSAC_CODE_FILL | {2'b00, ci_up_code_in, 2'b00};
	// frame updates own the write port; a host store waits for as long as up_change stays high
	wire cm_host_wr = cm_wr_pend_q & ~up_change;

	// downstream code with the arbitration bit overridden on port 0 slots of enabled channels
	wire [7:0] dn_entry = cm_q[{1'b0, ci_dn_addr_in}];
	wire dn_arb = (ci_dn_addr_in[1:0] == 2'b00) && arb_en_q[chan_of(ci_dn_addr_in)];
	wire [3:0] dn_code = dn_arb ?
		(code_of(dn_entry) & 4'hB) : code_of(dn_entry);

	// read mux
	wire [7:0] ext_val = q_empty ? LSAC_RST_BYTE : LSAC_EXT_QUEUE_VALID;
	wire [7:0] q_val = q_empty ? LSAC_RST_BYTE : q_head;
	wire [7:0] rd_byte = ({8{hit_data}} & mem_data_q) |
		({8{hit_addr}} & mem_addr_q) |
		({8{hit_ext}} & ext_val) |
		({8{hit_queue}} & q_val) |
		({8{hit_arb}} & arb_en_q) |
		({8{hit_dest}} & xmit_dest_q) |
		({8{hit_hstat}} & int_stat_q) |
		({8{hit_en}} & int_en_q);

	// sticky status: set wins over the write-one clear
	wire [7:0] int_set = ({7'h00, up_change & q_full} << LSAC_INT_OVF_BIT) |
		({7'h00, xmit_busy_q & xmit_done_in} << LSAC_INT_XPR_BIT);
	wire [7:0] int_clr = (wr_ok & hit_clr) ? wbyte : LSAC_RST_BYTE;
	assign int_stat_d = ((int_stat_q & ~int_clr) | int_set) & LSAC_INT_MASK;
	// queue level drives its own source so the line drops once drained
	wire irq_d = (|(int_stat_q & int_en_q)) |
		(~q_empty & int_en_q[LSAC_INT_CHG_BIT]);

	// fetched data replaces the data register at the edge where the command commits
	assign mem_data_d = (wr_ok & hit_data) ? wbyte : cm_q[mem_addr_q];

	lsac_change_queue u_queue
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.push_in(up_change),
		.push_data_in(up_addr),
		.pop_in(rd_pop),
		.head_out(q_head),
		.empty_out(q_empty),
		.full_out(q_full)
	);

	// bus answer: two wait cycles so read data leaves a flip-flop
	always_comb
	begin
		st_d = st_q;
		case (st_q)
			LSAC_ST_IDLE:
				if (psel_in & penable_in)
					st_d = LSAC_ST_LOAD;
			LSAC_ST_LOAD:
				st_d = LSAC_ST_DONE;
			LSAC_ST_DONE:
				st_d = LSAC_ST_IDLE;
			default:
				st_d = LSAC_ST_IDLE;
		endcase
	end

	// answer registers: ready, error and read data all leave flip-flops together
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			st_q <= LSAC_ST_IDLE;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end
		else
		begin
			st_q <= st_d;
			pready_q <= (st_d == LSAC_ST_DONE);
			pslverr_q <= (st_d == LSAC_ST_DONE) & ~hit_any;
			prdata_q <= (st_d == LSAC_ST_DONE) ? {24'h000000, rd_byte} : '0;
		end
	end

	// connection memory writes, no reset beyond the preload below
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			for (int i = 0; i < 256; i++)
				cm_q[i] <= LSAC_RST_MEM;
		end
		else if (up_change)
			cm_q[up_addr] <= up_new;
		else if (cm_host_wr)
			cm_q[mem_addr_q] <= mem_data_q;
	end

	// memory access registers and the deferred host store
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			mem_data_q <= LSAC_RST_BYTE;
			mem_addr_q <= LSAC_RST_BYTE;
			cm_wr_pend_q <= 1'b0;
		end
		else
		begin
			if ((wr_ok & hit_data) | wr_cmd_fetch)
				mem_data_q <= mem_data_d;
			if (wr_ok & hit_addr)
				mem_addr_q <= wbyte;
			if (wr_cmd_store)
				cm_wr_pend_q <= 1'b1;
			else if (cm_host_wr)
				cm_wr_pend_q <= 1'b0;
		end
	end

	// configuration registers, written only by the host
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			arb_en_q <= LSAC_RST_BYTE;
			xmit_dest_q <= LSAC_RST_BYTE;
			int_en_q <= LSAC_RST_INT_EN;
		end
		else
		begin
			if (wr_ok & hit_arb)
				arb_en_q <= wbyte;
			if (wr_ok & hit_dest)
				xmit_dest_q <= wbyte;
			if (wr_ok & hit_en)
				int_en_q <= wbyte & LSAC_INT_MASK;
		end
	end

	// sticky status; the next value already merges set and clear
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			int_stat_q <= LSAC_RST_BYTE;
		else
			int_stat_q <= int_stat_d;
	end

	// hdlc transmit handshake and receive reset pulses
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			xmit_busy_q <= 1'b0;
			xmit_start_q <= 1'b0;
			rx_reset_q <= 1'b0;
		end
		else
		begin
			xmit_start_q <= wr_hcmd_xmit;
			rx_reset_q <= wr_hcmd_rres;
			if (wr_hcmd_xmit)
				xmit_busy_q <= 1'b1;
			else if (xmit_done_in)
				xmit_busy_q <= 1'b0;
		end
	end

	// interrupt line and downstream code answer; code holds between requests
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			irq_q <= 1'b0;
			ci_dn_valid_q <= 1'b0;
			ci_dn_code_q <= 4'hF;
		end
		else
		begin
			irq_q <= irq_d;
			ci_dn_valid_q <= ci_dn_req_in;
			if (ci_dn_req_in)
				ci_dn_code_q <= dn_code;
		end
	end

	assign prdata_out = prdata_q;
	assign pready_out = pready_q;
	assign pslverr_out = pslverr_q;
	assign irq_out = irq_q;
	assign ci_dn_valid_out = ci_dn_valid_q;
	assign ci_dn_code_out = ci_dn_code_q;
	assign xmit_channel_out = xmit_dest_q;
	assign xmit_start_out = xmit_start_q;
	assign rx_reset_out = rx_reset_q;
endmodule // lsac_top
`default_nettype wire

// ==== tb/lsac_top_checker.sv ====
`default_nettype none
module lsac_top_checker
	import lsac_pkg::*;
(
	input wire logic clk_in, // clock
	input wire logic sys_rst_in, // reset
	input wire logic psel_in, // select
	input wire logic penable_in, // access
	input wire logic pwrite_in, // write
	input wire logic [11:0] paddr_in, // address
	input wire logic [31:0] pwdata_in, // wdata
	input wire logic [31:0] prdata_out, // rdata
	input wire logic pready_out, // ready
	input wire logic pslverr_out, // error
	input wire logic ci_dn_req_in, // dn req
	input wire logic ci_dn_valid_out, // dn valid
	input wire logic [3:0] ci_dn_code_out, // dn code
	input wire logic [7:0] xmit_channel_out, // dest
	input wire logic xmit_start_out, // send pulse
	input wire logic rx_reset_out // receive reset pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	wire logic wr_done;
	// write lands only at the edge that sees ready
	assign wr_done = psel_in & penable_in & pready_out & pwrite_in;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	property p_rdy_at;
		psel_in && penable_in && !$past(penable_in) |-> ##2 pready_out;
	endproperty
	a_rdy_at: assert property (p_rdy_at) else $error("ready not on third cycle");
	property p_rdy_one;
		pready_out |=> !pready_out;
	endproperty
	a_rdy_one: assert property (p_rdy_one) else $error("ready held too long");
	property p_rd_idle;
		!pready_out |-> prdata_out == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside ready");
	property p_rd_hi;
		prdata_out[31:8] == 24'h0;
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("upper read data set");
	property p_err;
		pslverr_out |-> pready_out;
	endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_err_data;
		pslverr_out |-> prdata_out == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data) else $error("data with error");
	property p_dn_ans;
		ci_dn_req_in |=> ci_dn_valid_out;
	endproperty
	a_dn_ans: assert property (p_dn_ans) else $error("no downstream answer");
	property p_dn_hold;
		!ci_dn_req_in |=> !ci_dn_valid_out && $stable(ci_dn_code_out);
	endproperty
	a_dn_hold: assert property (p_dn_hold) else $error("downstream code moved");
	property p_xstart;
		wr_done && paddr_in == {4'h0, LSAC_OFF_HDLC_CMD} && pwdata_in[7:0] == LSAC_HCMD_XMIT_END
		|=> xmit_start_out ##1 !xmit_start_out;
	endproperty
	a_xstart: assert property (p_xstart) else $error("send pulse wrong");
	property p_rxres;
		wr_done && paddr_in == {4'h0, LSAC_OFF_HDLC_CMD} && pwdata_in[7:0] == LSAC_HCMD_RX_RESET
		|=> rx_reset_out ##1 !rx_reset_out;
	endproperty
	a_rxres: assert property (p_rxres) else $error("receive reset pulse wrong");
	property p_xdest;
		wr_done && paddr_in == {4'h0, LSAC_OFF_XMIT_DEST}
		|=> xmit_channel_out == $past(pwdata_in[7:0]);
	endproperty
	a_xdest: assert property (p_xdest) else $error("destination not taken");
endmodule // lsac_top_checker
bind lsac_top lsac_top_checker chk_i (.clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .ci_dn_req_in,
	.ci_dn_valid_out, .ci_dn_code_out, .xmit_channel_out, .xmit_start_out, .rx_reset_out);
`default_nettype wire

// ==== tb/lsac_line_model.sv ====
`default_nettype none
module lsac_line_model
(
	input wire logic clk_in, // clock
	input wire logic go_in, // start activation
	input wire logic [6:0] slot_in, // slot and port
	output logic up_valid_out = 1'b0, // code strobe
	output logic [6:0] up_addr_out = 7'h00, // slot of code
	output logic [3:0] up_code_out = 4'h0 // upstream code
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] step_q = 2'h0;
	// three changes per activation; idle lines toggle so stale values never look valid
	always @(posedge clk_in)
	begin
		if (go_in)
			step_q <= 2'h3;
		else if (step_q != 2'h0)
			step_q <= step_q - 2'h1;
		up_valid_out <= step_q != 2'h0;
		up_addr_out <= (step_q != 2'h0) ? slot_in : ~up_addr_out;
		// steps 3, 2, 1 give codes 1100, 1000, 1100: the line settles on activated
		if (step_q == 2'h0)
			up_code_out <= ~up_code_out;
		else if (step_q == 2'h2)
			up_code_out <= 4'h8;
		else
			up_code_out <= 4'hC;
	end
endmodule // lsac_line_model
`default_nettype wire

// ==== tb/test_lsac_top.sv ====
`default_nettype none
module test_lsac_top
	import lsac_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic ci_dn_req_in = 1'b0, xmit_done_in = 1'b0, go = 1'b0, erv;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0, rdv;
	logic [6:0] ci_dn_addr_in = 7'h00, a;
	logic [7:0] d, en;
	wire logic [31:0] prdata_out;
	wire logic pready_out, pslverr_out, irq_out, ci_dn_valid_out, xmit_start_out, rx_reset_out;
	wire logic ci_up_valid_in;
	wire logic [3:0] ci_dn_code_out, ci_up_code_in;
	wire logic [6:0] ci_up_addr_in;
	wire logic [7:0] xmit_channel_out;
	int err_total = 0, checks_done = 0, cyc = 0, seed = 93;
	always #2.5 clk_in = ~clk_in;
	lsac_top dut (.clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
		.prdata_out, .pready_out, .pslverr_out, .irq_out, .ci_up_valid_in, .ci_up_addr_in,
		.ci_up_code_in, .ci_dn_req_in, .ci_dn_addr_in, .ci_dn_valid_out, .ci_dn_code_out,
		.xmit_channel_out, .xmit_start_out, .rx_reset_out, .xmit_done_in);
	lsac_line_model line (.clk_in, .go_in(go), .slot_in(7'h18), .up_valid_out(ci_up_valid_in),
		.up_addr_out(ci_up_addr_in), .up_code_out(ci_up_code_in));
	// arbitration clears bit 2 only on enabled port 0 channels
	function automatic logic [3:0] dn_code(logic [7:0] v, logic [6:0] s, logic [7:0] m);
		dn_code = v[5:2];
		if (s[1:0] == 2'h0 && m[s[6:4]])
			dn_code[2] = 1'b0;
	endfunction
	task automatic chk(logic [31:0] g, logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic give_verdict;
		$display("mismatches %0d compares %0d", err_total, checks_done);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// one transfer; the global cycle limit bounds the wait
	task automatic apb(logic w, logic [7:0] ad, logic [7:0] v);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= {4'h0, ad};
		pwdata_in <= {24'h0, v};
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rdv = prdata_out;
		erv = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic dn(logic [6:0] s, logic [3:0] e);
		@(posedge clk_in);
		ci_dn_req_in <= 1'b1;
		ci_dn_addr_in <= s;
		@(posedge clk_in);
		ci_dn_req_in <= 1'b0;
		#1;
		chk({31'h0, ci_dn_valid_out}, 32'h1);
		chk({28'h0, ci_dn_code_out}, {28'h0, e});
	endtask
	task automatic cm_wr(logic [7:0] ad, logic [7:0] v);
		apb(1'b1, LSAC_OFF_MEM_DATA, v);
		apb(1'b1, LSAC_OFF_MEM_ADDR, ad);
		apb(1'b1, LSAC_OFF_MEM_CMD, LSAC_CMD_MEM_WRITE);
	endtask
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (12) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		apb(1'b0, LSAC_OFF_EXT_STAT, 8'h00);
		chk(rdv, 32'h0);
		cm_wr(8'h18, 8'h30);
		dn(7'h18, 4'hC);
		@(posedge clk_in);
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
		repeat (10) @(posedge clk_in);
		apb(1'b0, LSAC_OFF_EXT_STAT, 8'h00);
		chk(rdv, {24'h0, LSAC_EXT_QUEUE_VALID});
		repeat (3)
		begin
			chk({31'h0, irq_out}, 32'h1);
			apb(1'b0, LSAC_OFF_CHG_QUEUE, 8'h00);
			chk(rdv, {24'h0, 1'b1, 7'h18});
		end
		repeat (2) @(posedge clk_in);
		#1 chk({31'h0, irq_out}, 32'h0);
		apb(1'b1, LSAC_OFF_MEM_ADDR, 8'h98);
		apb(1'b1, LSAC_OFF_MEM_CMD, LSAC_CMD_MEM_READ);
		apb(1'b0, LSAC_OFF_MEM_DATA, 8'h00);
		chk(rdv, {24'h0, LSAC_CODE_FILL | 8'h30});
		apb(1'b1, LSAC_OFF_ARB_EN, 8'h03);
		dn(7'h18, 4'h8);
		// channel 0 enabled too; a port 1 slot on channel 1 keeps its stored code
		dn(7'h08, 4'hB);
		dn(7'h19, 4'hF);
		// random memory, enables and destinations
		repeat (6)
		begin
			d = 8'($random(seed));
			a = 7'($random(seed));
			en = 8'($random(seed));
			cm_wr({1'b0, a}, d);
			apb(1'b1, LSAC_OFF_ARB_EN, en);
			apb(1'b1, LSAC_OFF_XMIT_DEST, d);
			dn(a, dn_code(d, a, en));
			chk({24'h0, xmit_channel_out}, {24'h0, d});
		end
		apb(1'b1, LSAC_OFF_HDLC_CMD, LSAC_HCMD_XMIT_END);
		#1 chk({31'h0, xmit_start_out}, 32'h1);
		@(posedge clk_in);
		xmit_done_in <= 1'b1;
		@(posedge clk_in);
		xmit_done_in <= 1'b0;
		apb(1'b0, LSAC_OFF_HDLC_STAT, 8'h00);
		chk(rdv, 32'h1 << LSAC_INT_XPR_BIT);
		chk({31'h0, irq_out}, 32'h1);
		apb(1'b1, LSAC_OFF_INT_CLR, 8'h10);
		repeat (2) @(posedge clk_in);
		#1 chk({31'h0, irq_out}, 32'h0);
		apb(1'b1, LSAC_OFF_HDLC_CMD, LSAC_HCMD_RX_RESET);
		#1 chk({31'h0, rx_reset_out}, 32'h1);
		apb(1'b0, 8'h40, 8'h00);
		chk({31'h0, erv}, 32'h1);
		chk(rdv, 32'h0);
		give_verdict();
	end
endmodule // test_lsac_top
`default_nettype wire
